// file: idp_top.v
/*
 ISA digital I/O port: 32 lines in four 8-bit ports with per-line
 direction, spare timing lines, resource selection by Plug and Play
 snooping or switchless register writes, host I/O window decode,
 AXI4-Lite register slave and a masked level interrupt.
 Assumes host bus and line inputs are asynchronous; AXI is on clock_i.
*/
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
// Functional notes
// - Base from 0x100 to 0x3e0 only
// - Sixteen byte window, base 16-aligned
// - At most two 16-bit DMA channels
// - DMA 5-7 on ISA, 0-3,5-7 on EISA
// - One IRQ from legal set only
// - Plug and Play resource assignment accepted
// - Switchless mode: software writes resources
// - Watch configuration ports 0x279 and 0xa79
// - Four 8-bit ports, host read/write; here the host only reads them, port writes come over AXI
// - Per-line direction setting
// - Unstrobed: read levels, write outputs
// - Spare inputs: strobe and halt trigger
// - Spare outputs: reply and transfer clock
// - Strobed mode: lines form timing set; here it only turns off the reply and transfer clock drives
`default_nettype none
`include "idp_regs.vh"

module idp_top (
  input  wire        clock_i,         // 40 MHz clock
  input  wire        rst_i,           // Synchronous reset
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output wire        s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output wire        s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [7:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output wire        s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read valid
  input  wire        s_axi_rready,    // Read ready
  // Host ISA bus
  input  wire [11:0] isa_addr_i,      // Host I/O address
  input  wire [7:0]  isa_data_i,      // Host write data
  input  wire        isa_iow_n_i,     // Host I/O write, active low
  input  wire        isa_ior_n_i,     // Host I/O read, active low
  output reg  [7:0]  isa_data_o,      // Host read data
  output reg         isa_data_oe_o,   // Host data drive enable
  output reg  [3:0]  isa_irq_sel_o,   // Selected IRQ line number
  output reg         isa_irq_o,       // Interrupt request to host
  output reg  [3:0]  isa_dma0_sel_o,  // Selected DMA channel 0
  output reg  [3:0]  isa_dma1_sel_o,  // Selected DMA channel 1
  output reg  [1:0]  isa_dma_en_o,    // DMA channels in use
  // Line side
  input  wire [31:0] port_i,          // Port A..D line levels
  output reg  [31:0] port_o,          // Port A..D output values
  output reg  [31:0] port_oe_o,       // Port A..D output enables
  input  wire        strobe_in_i,     // Incoming strobe line
  input  wire        halt_trigger_line_i, // Halt trigger line
  output reg         reply_o,         // Handshake reply line
  output reg         reply_oe_o,      // Reply drive enable
  output reg         xfer_clk_o,      // Transfer clock line
  output reg         xfer_clk_oe_o,   // Transfer clock drive enable
  output wire        irq_o            // Level interrupt to AXI side
);
  // Synchronisers
  reg [31:0] port_s1, port_s2, port_prev;
  reg [1:0]  spare_s1, spare_s2, spare_prev;
  reg [11:0] addr_s1, addr_s2;
  reg [7:0]  hdat_s1, hdat_s2;
  reg [1:0]  hstb_s1, hstb_s2, hstb_prev;

  always @(posedge clock_i) begin
    port_s1  <= port_i;
    port_s2  <= port_s1;
    spare_s1 <= {halt_trigger_line_i, strobe_in_i};
    spare_s2 <= spare_s1;
    addr_s1  <= isa_addr_i;
    addr_s2  <= addr_s1;
    hdat_s1  <= isa_data_i;
    hdat_s2  <= hdat_s1;
    hstb_s1  <= {~isa_ior_n_i, ~isa_iow_n_i};
    hstb_s2  <= hstb_s1;
  end

  wire host_wr = hstb_s2[0] & ~hstb_prev[0];
  wire host_rd = hstb_s2[1];

  // Registers
  reg [31:0] data_out, dir;
  reg [1:0]  spare_out;
  reg [9:0]  base_sw;
  reg [13:0] res_sw;
  reg [2:0]  ctrl;
  reg [3:0]  irq_stat, irq_mask;

  wire [9:0] pnp_base;
  wire [3:0] pnp_irq, pnp_dma0, pnp_dma1;
  wire       pnp_active, pnp_update;

  idp_pnp_snoop u_snoop (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .iow_i    (host_wr),
    .addr_i   (addr_s2),
    .data_i   (hdat_s2),
    .base_o   (pnp_base),
    .irq_o    (pnp_irq),
    .dma0_o   (pnp_dma0),
    .dma1_o   (pnp_dma1),
    .active_o (pnp_active),
    .update_o (pnp_update)
  );

  // Resource legality checks
  function base_ok;
    input [9:0] b;
    begin
      base_ok = (b >= `IDP_BASE_MIN) && (b <= `IDP_BASE_MAX) &&
                (b[`IDP_WIN_BITS-1:0] == 4'h0);
    end
  endfunction

  function dma_ok;
    input [3:0] ch;
    input       eisa;
    reg   [7:0] legal;
    begin
      legal  = eisa ? `IDP_DMA_LEGAL_EISA : `IDP_DMA_LEGAL_ISA;
      dma_ok = ~ch[3] & legal[ch[2:0]];
    end
  endfunction

  // Switchless mode uses software registers; otherwise Plug and Play
  wire       sw_mode  = ~pnp_active;
  wire [9:0] eff_base = sw_mode ? base_sw : pnp_base;
  wire [3:0] eff_irq  = sw_mode ? res_sw[3:0] : pnp_irq;
  wire [3:0] eff_dma0 = sw_mode ? res_sw[7:4] : pnp_dma0;
  wire [3:0] eff_dma1 = sw_mode ? res_sw[11:8] : pnp_dma1;
  wire       want0    = sw_mode ? res_sw[`IDP_RES_DMA0_EN] : 1'b1;
  wire       want1    = sw_mode ? res_sw[`IDP_RES_DMA1_EN] : 1'b1;
  wire       eisa     = ctrl[`IDP_CTRL_EISA];

  wire base_good = base_ok(eff_base);
  wire [15:0] irq_legal = `IDP_IRQ_LEGAL;
  wire irq_good  = irq_legal[eff_irq];
  wire dma0_good = want0 & dma_ok(eff_dma0, eisa);
  wire dma1_good = want1 & dma_ok(eff_dma1, eisa) &
                   ~(dma0_good & (eff_dma1 == eff_dma0));
  wire enabled   = base_good & (ctrl[`IDP_CTRL_ENABLE] | pnp_active);

  // Host window decode
  wire       in_win  = enabled && (addr_s2[11:4] == {2'b00, eff_base[9:4]});
  wire [3:0] win_off = addr_s2[3:0];
  wire       strobed = ctrl[`IDP_CTRL_STROBED];

  wire [31:0] line_val = (port_s2 & ~dir) | (data_out & dir);

  // Host side access and line drive
  always @(posedge clock_i) begin
    if (rst_i) begin
      isa_data_o    <= 8'h00;
      isa_data_oe_o <= 1'b0;
      port_o        <= `IDP_RST_DATA;
      port_oe_o     <= `IDP_RST_DIR;
      reply_o       <= 1'b0;
      reply_oe_o    <= 1'b0;
      xfer_clk_o    <= 1'b0;
      xfer_clk_oe_o <= 1'b0;
      isa_irq_sel_o <= 4'h0;
      isa_irq_o     <= 1'b0;
      isa_dma0_sel_o <= 4'h0;
      isa_dma1_sel_o <= 4'h0;
      isa_dma_en_o  <= 2'b00;
    end else begin
      isa_data_oe_o <= host_rd & in_win;
      case (win_off[3:2])
        2'd0:    isa_data_o <= line_val[8*win_off[1:0] +: 8];
        2'd1:    isa_data_o <= dir[8*win_off[1:0] +: 8];
        2'd2:    isa_data_o <= {6'h00, spare_s2};
        default: isa_data_o <= 8'h00;
      endcase
      port_o        <= data_out;
      port_oe_o     <= dir;
      reply_o       <= spare_out[0];
      xfer_clk_o    <= spare_out[1];
      reply_oe_o    <= ~strobed;
      xfer_clk_oe_o <= ~strobed;
      isa_irq_sel_o <= eff_irq;
      isa_irq_o     <= enabled & irq_good & irq_o;
      isa_dma0_sel_o <= eff_dma0;
      isa_dma1_sel_o <= eff_dma1;
      isa_dma_en_o  <= {enabled & dma1_good, enabled & dma0_good};
    end
  end

  // AXI4-Lite slave
  reg        aw_held, w_held;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire aw_in = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_in  = w_held | (s_axi_wvalid & s_axi_wready);
  wire do_wr = aw_in & w_in & ~s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (st[k])
          merge[8*k +: 8] = nw[8*k +: 8];
    end
  endfunction

  wire [31:0] in_diff    = (port_s2 ^ port_prev) & ~dir;
  wire [3:0]  irq_events = {pnp_update, 1'b0, 1'b0, 1'b0} |
                           {1'b0, enabled & ~(irq_good & base_good), |(spare_s2 ^ spare_prev),
                            |in_diff};
  wire [3:0]  irq_clr    = (do_wr && wa == `IDP_REG_IRQ_STAT) ? wd[3:0] & {4{ws[0]}} : 4'h0;
  wire [31:0] merged     = merge(32'h0, wd, ws);
  wire [31:0] res_merged = merge({18'h0, res_sw}, wd, ws);

  always @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IDP_AXI_OKAY;
      data_out <= `IDP_RST_DATA;
      dir <= `IDP_RST_DIR;
      spare_out <= 2'b00;
      base_sw <= `IDP_RST_BASE;
      res_sw <= `IDP_RST_RES;
      ctrl <= 3'b000;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      port_prev <= 32'h0;
      spare_prev <= 2'b00;
      hstb_prev <= 2'b00;
    end else begin
      port_prev  <= port_s2;
      spare_prev <= spare_s2;
      hstb_prev  <= hstb_s2;
      irq_stat   <= (irq_stat & ~irq_clr) | irq_events;               // Set wins
      if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IDP_AXI_OKAY;
        case (wa)
          `IDP_REG_PORT_DATA: data_out <= merge(data_out, wd, ws);
          `IDP_REG_PORT_DIR:  dir <= merge(dir, wd, ws);
          `IDP_REG_SPARE:     if (ws[0]) spare_out <= wd[1:0];
          `IDP_REG_BASE_ADDR: base_sw <= {merged[9:4], 4'h0};
          `IDP_REG_RES_SEL:   res_sw <= res_merged[13:0];
          `IDP_REG_CTRL:      if (ws[0]) ctrl <= wd[2:0];
          `IDP_REG_IRQ_STAT:  ;
          `IDP_REG_IRQ_MASK:  if (ws[0]) irq_mask <= wd[3:0];
          default:            s_axi_bresp <= `IDP_AXI_SLVERR;
        endcase
      end
    end
  end

  // Host window writes reach only the configuration snooper
  assign irq_o = |(irq_stat & irq_mask);

  always @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `IDP_AXI_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `IDP_AXI_OKAY;
      case (s_axi_araddr)
        `IDP_REG_PORT_DATA: s_axi_rdata <= data_out;
        `IDP_REG_PORT_DIR:  s_axi_rdata <= dir;
        `IDP_REG_PORT_IN:   s_axi_rdata <= line_val;
        `IDP_REG_SPARE:     s_axi_rdata <= {28'h0, spare_s2, spare_out};
        `IDP_REG_BASE_ADDR: s_axi_rdata <= {22'h0, eff_base};
        `IDP_REG_RES_SEL:   s_axi_rdata <= {18'h0, res_sw};
        `IDP_REG_CTRL:      s_axi_rdata <= {29'h0, ctrl};
        `IDP_REG_IRQ_STAT:  s_axi_rdata <= {28'h0, irq_stat};
        `IDP_REG_IRQ_MASK:  s_axi_rdata <= {28'h0, irq_mask};
        `IDP_REG_PNP_STAT:  s_axi_rdata <= {27'h0, enabled, dma1_good, dma0_good,
                                            irq_good, pnp_active};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `IDP_AXI_SLVERR;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: idp_regs.vh
/*
 Constants for the ISA digital I/O port: register offsets, field positions,
 reset values, configuration-port addresses and legal resource choices.
 Assumes inclusion by bare name from the design files.
*/
`ifndef IDP_REGS_VH
`define IDP_REGS_VH

// AXI4-Lite register byte offsets
`define IDP_REG_PORT_DATA    8'h00
`define IDP_REG_PORT_DIR     8'h04
`define IDP_REG_PORT_IN      8'h08
`define IDP_REG_SPARE        8'h0c
`define IDP_REG_BASE_ADDR    8'h10
`define IDP_REG_RES_SEL      8'h14
`define IDP_REG_CTRL         8'h18
`define IDP_REG_IRQ_STAT     8'h1c
`define IDP_REG_IRQ_MASK     8'h20
`define IDP_REG_PNP_STAT     8'h24

// Reset values
`define IDP_RST_DIR          32'h0000_0000
`define IDP_RST_DATA         32'h0000_0000
`define IDP_RST_BASE         10'h000
`define IDP_RST_RES          14'h0000

// Base address limits and window
`define IDP_BASE_MIN         10'h100
`define IDP_BASE_MAX         10'h3e0
`define IDP_WIN_BITS         4

// Configuration port addresses watched on the host bus
`define IDP_CFG_ADDR_PORT    12'h279
`define IDP_CFG_WDATA_PORT   12'ha79

// Legal IRQ lines bitmap (3,4,5,6,7,9,10,11,12,14,15)
`define IDP_IRQ_LEGAL        16'hdef8
// Legal DMA channels, ISA 16-bit (5,6,7) and EISA (0-3,5-7)
`define IDP_DMA_LEGAL_ISA    8'he0
`define IDP_DMA_LEGAL_EISA   8'hef

// Resource select fields
`define IDP_RES_IRQ_LSB      0
`define IDP_RES_DMA0_LSB     4
`define IDP_RES_DMA1_LSB     8
`define IDP_RES_DMA0_EN      12
`define IDP_RES_DMA1_EN      13

// Control fields
`define IDP_CTRL_ENABLE      0
`define IDP_CTRL_EISA        1
`define IDP_CTRL_STROBED     2

// Plug and Play register indices used by the configuration snooper
`define IDP_PNP_IDX_BASE_HI  8'h60
`define IDP_PNP_IDX_BASE_LO  8'h61
`define IDP_PNP_IDX_IRQ      8'h70
`define IDP_PNP_IDX_DMA0     8'h74
`define IDP_PNP_IDX_DMA1     8'h75
`define IDP_PNP_IDX_ACTIVE   8'h30

// Interrupt status bits
`define IDP_IRQ_IN_CHANGE    0
`define IDP_IRQ_SPARE_CHANGE 1
`define IDP_IRQ_BAD_RES      2
`define IDP_IRQ_CFG_DONE     3

`define IDP_AXI_OKAY         2'b00
`define IDP_AXI_SLVERR       2'b10

`endif

// file: idp_pnp_snoop.v
/*
 Plug and Play configuration snooper: watches host bus writes to the
 address and write-data configuration ports and captures the base address,
 IRQ and DMA selections plus the activate bit.
 Assumes host bus strobes already synchronised to clock_i.
*/
`default_nettype none
`include "idp_regs.vh"

module idp_pnp_snoop (
  input  wire        clock_i,     // System clock
  input  wire        rst_i,       // Synchronous reset
  input  wire        iow_i,       // One-cycle host write strobe
  input  wire [11:0] addr_i,      // Host I/O address
  input  wire [7:0]  data_i,      // Host write data
  output reg  [9:0]  base_o,      // Captured base address
  output reg  [3:0]  irq_o,       // Captured IRQ line
  output reg  [3:0]  dma0_o,      // Captured DMA channel 0
  output reg  [3:0]  dma1_o,      // Captured DMA channel 1
  output reg         active_o,    // Activate bit
  output reg         update_o     // Pulse on any captured write
);
  reg [7:0] index;

  always @(posedge clock_i) begin
    if (rst_i) begin
      index    <= 8'h00;
      base_o   <= `IDP_RST_BASE;
      irq_o    <= 4'h0;
      dma0_o   <= 4'h4;
      dma1_o   <= 4'h4;
      active_o <= 1'b0;
      update_o <= 1'b0;
    end else begin
      update_o <= 1'b0;
      if (iow_i && addr_i == `IDP_CFG_ADDR_PORT) begin
        index <= data_i;
      end else if (iow_i && addr_i == `IDP_CFG_WDATA_PORT) begin
        update_o <= 1'b1;
        case (index)
          `IDP_PNP_IDX_BASE_HI: base_o[9:8] <= data_i[1:0];
          `IDP_PNP_IDX_BASE_LO: base_o[7:0] <= {data_i[7:4], 4'h0};
          `IDP_PNP_IDX_IRQ:     irq_o       <= data_i[3:0];
          `IDP_PNP_IDX_DMA0:    dma0_o      <= data_i[3:0];
          `IDP_PNP_IDX_DMA1:    dma1_o      <= data_i[3:0];
          `IDP_PNP_IDX_ACTIVE:  active_o    <= data_i[0];
          default:              update_o    <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: idp_top_chk.sv
/*
 Checker on the ports of idp_top, bound into every instance.
 Assumes idp_regs.vh on the include path and one clock domain.
*/
`default_nettype none
`include "idp_regs.vh"
module idp_top_chk (
  input wire logic        clock_i,        // Clock
  input wire logic        rst_i,          // Reset
  input wire logic        s_axi_arvalid,  // Read address valid
  input wire logic        s_axi_arready,  // Read address ready
  input wire logic        s_axi_rvalid,   // Read valid
  input wire logic        s_axi_rready,   // Read ready
  input wire logic [31:0] s_axi_rdata,    // Read data
  input wire logic [1:0]  s_axi_rresp,    // Read response
  input wire logic        s_axi_bvalid,   // Write response valid
  input wire logic        s_axi_bready,   // Write response ready
  input wire logic [1:0]  s_axi_bresp,    // Write response
  input wire logic        isa_ior_n_i,    // Host read strobe
  input wire logic        isa_data_oe_o,  // Host data enable
  input wire logic        isa_irq_o,      // Host interrupt
  input wire logic [3:0]  isa_irq_sel_o,  // IRQ number
  input wire logic [3:0]  isa_dma0_sel_o, // DMA channel 0
  input wire logic [3:0]  isa_dma1_sel_o, // DMA channel 1
  input wire logic [1:0]  isa_dma_en_o,   // DMA in use
  input wire logic [31:0] port_oe_o       // Line enables
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_waiting;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_lines_idle: assert property (@(posedge clock_i) disable iff (1'b0) $fell(rst_i) |->
    port_oe_o == 32'h0 && !isa_data_oe_o) else $error("line enable after reset");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_r_waiting |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read answer dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_irq_legal: assert property (isa_irq_o |->
    ((`IDP_IRQ_LEGAL >> isa_irq_sel_o) & 16'h0001) != 16'h0) else $error("bad IRQ line");
  a_dma_legal: assert property ((isa_dma_en_o[0] |-> !isa_dma0_sel_o[3]
    && isa_dma0_sel_o != 4'h4) and (isa_dma_en_o[1] |-> !isa_dma1_sel_o[3]
    && isa_dma1_sel_o != 4'h4)) else $error("bad DMA channel");
  a_dma_distinct: assert property (&isa_dma_en_o |-> isa_dma0_sel_o != isa_dma1_sel_o)
    else $error("DMA channels equal");
  a_read_cause: assert property (isa_data_oe_o |-> !$past(isa_ior_n_i, 1)
    || !$past(isa_ior_n_i, 2) || !$past(isa_ior_n_i, 3) || !$past(isa_ior_n_i, 4)
    || !$past(isa_ior_n_i, 5)) else $error("host data driven without read");
  a_dir_cause: assert property (!$stable(port_oe_o) |-> $past(s_axi_bvalid, 1)
    || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("direction moved alone");
endmodule
bind idp_top idp_top_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .isa_ior_n_i(isa_ior_n_i), .isa_data_oe_o(isa_data_oe_o),
  .isa_irq_o(isa_irq_o), .isa_irq_sel_o(isa_irq_sel_o), .isa_dma0_sel_o(isa_dma0_sel_o),
  .isa_dma1_sel_o(isa_dma1_sel_o), .isa_dma_en_o(isa_dma_en_o), .port_oe_o(port_oe_o));
`default_nettype wire

// file: idp_host_model.sv
/*
 Host bus model: I/O write and read cycles on the ISA side.
 Assumes the device synchronises the strobes to clock_i.
*/
`default_nettype none
module idp_host_model (
  input  wire logic        clock_i,    // Clock
  input  wire logic [7:0]  data_i,     // Device read data
  input  wire logic        data_oe_i,  // Device drives data
  output var  logic [11:0] addr_o,     // I/O address
  output var  logic [7:0]  data_o,     // Write data
  output var  logic        iow_n_o,    // Write strobe
  output var  logic        ior_n_o     // Read strobe
);
  initial begin
    addr_o = 12'h000;
    data_o = 8'h00;
    iow_n_o = 1'b1;
    ior_n_o = 1'b1;
  end
  // One device per window, so one base per cycle
  task automatic io_cycle(input logic [11:0] a, input logic [7:0] d, input logic wr,
                          output logic [7:0] q, output logic oe);
    @(posedge clock_i);
    addr_o <= a;
    data_o <= d;
    iow_n_o <= !wr;
    ior_n_o <= wr;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    q = data_i;
    oe = data_oe_i;
    @(posedge clock_i);
    iow_n_o <= 1'b1;
    ior_n_o <= 1'b1;
    // Released bus shows no stale value
    data_o <= ~d;
    repeat (4) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// file: test_isa_digital_io_port.sv
/*
 Self-checking bench for idp_top over AXI4-Lite and the host bus.
 Assumes idp_regs.vh on the include path.
*/
`default_nettype none
`include "idp_regs.vh"
module test_isa_digital_io_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, hd, ddo;
  logic [31:0] wdata = 32'h0, rdq, ext = 32'h0, port_o, port_oe_o;
  logic [3:0] wstrb = 4'hf, irqs, d0s, d1s;
  logic [1:0] bresp, rresp, rr, den, wresp;
  logic [11:0] ha;
  logic awready, wready, bvalid, arready, rvalid, iow_n, ior_n, doe, hoe, isa_irq, irq_o;
  logic strobe_in = 0, halt_in = 0, reply_o, reply_oe, xclk_o, xclk_oe;
  integer err_total = 0, comparisons = 0, i, e;
  wire [31:0] port_i = (port_oe_o & port_o) | (~port_oe_o & ext);
  always #12.5 clock_i = ~clock_i;
  idp_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdq), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .isa_addr_i(ha), .isa_data_i(hd),
    .isa_iow_n_i(iow_n), .isa_ior_n_i(ior_n), .isa_data_o(ddo), .isa_data_oe_o(doe),
    .isa_irq_sel_o(irqs), .isa_irq_o(isa_irq), .isa_dma0_sel_o(d0s), .isa_dma1_sel_o(d1s),
    .isa_dma_en_o(den), .port_i(port_i), .port_o(port_o), .port_oe_o(port_oe_o),
    .strobe_in_i(strobe_in), .halt_trigger_line_i(halt_in), .reply_o(reply_o),
    .reply_oe_o(reply_oe), .xfer_clk_o(xclk_o), .xfer_clk_oe_o(xclk_oe), .irq_o(irq_o));
  idp_host_model host (.clock_i(clock_i), .data_i(ddo), .data_oe_i(doe), .addr_o(ha),
    .data_o(hd), .iow_n_o(iow_n), .ior_n_o(ior_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic no_answer;
    err_total = err_total + 1;
    $display("Error at %0t: bus gave no answer", $time);
    end_of_test;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int n;
    logic pa, pw, ta, tw, got;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    pa = 1;
    pw = 1;
    got = 0;
    for (n = 0; n < 40 && (pa || pw); n++) begin
      @(negedge clock_i);
      ta = awready;
      tw = wready;
      @(posedge clock_i);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge clock_i);
      got = bvalid;
      wresp = bresp;
      @(posedge clock_i);
    end
    bready <= 0;
    @(posedge clock_i);
    if (!got || pa || pw) no_answer;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    int n;
    logic ta, got;
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    ta = 0;
    got = 0;
    for (n = 0; n < 40 && !ta; n++) begin
      @(negedge clock_i);
      ta = arready;
      @(posedge clock_i);
    end
    arvalid <= 0;
    for (n = 0; n < 40 && !got; n++) begin
      @(negedge clock_i);
      got = rvalid;
      q = rdq;
      r = rresp;
      @(posedge clock_i);
    end
    rready <= 0;
    if (!got || !ta) no_answer;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic [1:0] r;
    rd(a, q, r);
    check(q & m, exp);
  endtask
  task automatic hr(input logic [11:0] a, input logic oe, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    host.io_cycle(a, 8'h00, 1'b0, q, o);
    check(o, oe);
    if (oe) check(q, d);
  endtask
  task automatic done(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_total);
  endtask
  logic [11:0] bases [4] = '{12'h0f0, 12'h3f0, 12'h3e0, 12'h100};
  logic [19:0] pnp [8] = '{20'h27960, 20'ha7902, 20'h27961, 20'ha7980, 20'h27970,
                           20'ha790a, 20'h27930, 20'ha7901};
  initial begin
    logic [7:0] q;
    logic o;
    logic [31:0] rq;
    repeat (10) @(posedge clock_i);
    rst_i <= 0;
    @(negedge clock_i);
    check(port_oe_o, 32'h0);
    check({isa_irq, den}, 3'b000);
    rc(`IDP_REG_PORT_DIR, 32'h0, 32'hffff_ffff);
    hr(12'h100, 1'b0, 8'h00);
    done("reset");
    wr(`IDP_REG_CTRL, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(`IDP_REG_BASE_ADDR, {20'h0, bases[i]});
      rc(`IDP_REG_PNP_STAT, {27'h0, i > 1, 4'h0}, 32'h10);
    end
    ext = 32'h4433_2211;
    hr(12'h100, 1'b1, 8'h11);
    hr(12'h103, 1'b1, 8'h44);
    hr(12'h110, 1'b0, 8'h00);
    hr(12'h0f0, 1'b0, 8'h00);
    done("window");
    for (i = 0; i < 16; i++) begin
      wr(`IDP_REG_RES_SEL, i);
      // Lines 3-7, 9-12, 14, 15 are legal
      rc(`IDP_REG_PNP_STAT, {30'h0, 16'hdef8 >> i, 1'b0} & 32'h2, 32'h2);
    end
    for (e = 0; e < 2; e++)
      for (i = 0; i < 8; i++) begin
        wr(`IDP_REG_CTRL, 1 | e << 1);
        wr(`IDP_REG_RES_SEL, 32'h1000 | i << 4);
        rc(`IDP_REG_PNP_STAT, (e ? i != 4 : i >= 5) << 2, 32'h4);
      end
    wr(`IDP_REG_RES_SEL, 32'h3565);
    check({irqs, d0s, d1s, den}, {4'h5, 4'h6, 4'h5, 2'b11});
    wr(`IDP_REG_RES_SEL, 32'h3666);
    check(&den, 1'b0);
    done("resources");
    wr(`IDP_REG_PORT_DIR, 32'h0000_00ff);
    wr(`IDP_REG_PORT_DIR, 32'hffff_ffff, 4'h2);
    wr(`IDP_REG_PORT_DATA, 32'ha5c3_5a3c);
    ext = 32'h1234_0000;
    repeat (4) @(posedge clock_i);
    check(port_oe_o, 32'h0000_ffff);
    check(port_o & port_oe_o, 32'h0000_5a3c);
    rc(`IDP_REG_PORT_IN, 32'h1234_5a3c, 32'hffff_ffff);
    hr(12'h104, 1'b1, 8'hff);
    done("ports");
    wr(`IDP_REG_SPARE, 32'h1);
    strobe_in <= 1;
    repeat (4) @(posedge clock_i);
    check({xclk_oe, reply_oe, xclk_o, reply_o}, 4'b1101);
    rc(`IDP_REG_SPARE, 32'h4, 32'hc);
    wr(`IDP_REG_CTRL, 32'h5);
    check(reply_oe, 1'b0);
    wr(`IDP_REG_CTRL, 32'h1);
    done("spare");
    wr(`IDP_REG_IRQ_STAT, 32'hf);
    wr(`IDP_REG_IRQ_MASK, 32'h1);
    check(irq_o, 1'b0);
    ext = 32'h5678_0000;
    repeat (4) @(posedge clock_i);
    check(irq_o, 1'b1);
    wr(`IDP_REG_IRQ_MASK, 32'h0);
    check(irq_o, 1'b0);
    wr(`IDP_REG_IRQ_MASK, 32'h1);
    check(irq_o, 1'b1);
    wr(`IDP_REG_IRQ_STAT, 32'h1);
    check(irq_o, 1'b0);
    rd(8'h40, rq, rr);
    check(rr, `IDP_AXI_SLVERR);
    wr(8'h40, 32'h0);
    check(wresp, `IDP_AXI_SLVERR);
    done("interrupt");
    wr(`IDP_REG_CTRL, 32'h0);
    for (i = 0; i < 8; i++) host.io_cycle(pnp[i][19:8], pnp[i][7:0], 1'b1, q, o);
    rc(`IDP_REG_PNP_STAT, 32'h1, 32'h1);
    check(irqs, 4'ha);
    rc(`IDP_REG_IRQ_STAT, 32'h8, 32'h8);
    hr(12'h280, 1'b1, 8'h3c);
    done("plug and play");
    end_of_test;
  end
endmodule
`default_nettype wire
